// ==== hw/plcr_top.sv ====
// link capabilities and link control registers on the configuration port
`timescale 1ns/100ps
`include "plcr_map.svh"
module plcr_top
   import plcr_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic cfg_rd,
   input wire logic cfg_wr,
   input wire logic [ADDR_W-1:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_rvalid,
   output logic cfg_wack,
   input wire logic [2:0] diag_l1_exit_sel_a,
   input wire logic [2:0] diag_l1_exit_sel_b,
   input wire logic refclk_gating_default,
   input wire logic [1:0] aspm_control_default,
   output logic refclk_gating_enable,
   output logic extended_sync,
   output logic ccc,
   output logic rcb,
   output logic [1:0] aspm_control
);
   // ***********************************************************************
   // parameter check
   // ***********************************************************************
   if (ADDR_W < 8 || ADDR_W > 12) begin : g_bad_addr_w
      $error("plcr_top: ADDR_W must lie between 8 and 12");
   end

   // byte offsets cut to the port width on purpose, then reduced to dword indices
   localparam logic [ADDR_W-1:0] CAP_ADDR = ADDR_W'(`PLCR_OFF_LINK_CAP);
   localparam logic [ADDR_W-1:0] CTRL_ADDR = ADDR_W'(`PLCR_OFF_LINK_CTRL);
   localparam logic [ADDR_W-3:0] CAP_IDX = CAP_ADDR[ADDR_W-1:`PLCR_DWORD_LSB];
   localparam logic [ADDR_W-3:0] CTRL_IDX = CTRL_ADDR[ADDR_W-1:`PLCR_DWORD_LSB];

   // ***********************************************************************
   // start-up sequencing
   // ***********************************************************************
   // one cycle after release the strap defaults are loaded; writes in that
   // cycle are dropped so the documented reset image is never skipped
   plcr_state_t st_q, st_d;
   logic load_defaults;

   always_comb begin
      st_d = st_q;
      load_defaults = 1'b0;
      unique case (st_q)
         PLCR_ST_LOAD: begin
            load_defaults = 1'b1;
            st_d = PLCR_ST_RUN;
         end
         PLCR_ST_RUN: begin
            st_d = PLCR_ST_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= PLCR_ST_LOAD;
      end else begin
         st_q <= st_d;
      end
   end

   // ***********************************************************************
   // address decode
   // ***********************************************************************
   logic [ADDR_W-3:0] dw_idx;
   logic hit_cap;
   logic hit_ctrl;
   logic ctrl_wr_lo;
   logic ctrl_wr_hi;

   assign dw_idx = cfg_addr[ADDR_W-1:`PLCR_DWORD_LSB];
   assign hit_cap = (dw_idx == CAP_IDX);
   assign hit_ctrl = (dw_idx == CTRL_IDX);

   // writes to the capabilities word fall through with no target
   always_comb begin
      ctrl_wr_lo = cfg_wr && hit_ctrl && cfg_be[0] && (st_q == PLCR_ST_RUN);
      ctrl_wr_hi = cfg_wr && hit_ctrl && cfg_be[1] && (st_q == PLCR_ST_RUN);
   end

   // ***********************************************************************
   // register contents
   // ***********************************************************************
   logic [31:0] cap_word;
   logic [15:0] lctl_word;

   plcr_link_ctrl u_link_ctrl (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .load_defaults(load_defaults),
      .refclk_gating_default(refclk_gating_default),
      .aspm_control_default(aspm_control_default),
      .wr_lo(ctrl_wr_lo),
      .wr_hi(ctrl_wr_hi),
      .wdata(cfg_wdata[15:0]),
      .refclk_gating_enable(refclk_gating_enable),
      .extended_sync(extended_sync),
      .ccc(ccc),
      .rcb(rcb),
      .aspm_control(aspm_control),
      .lctl_word(lctl_word)
   );

   plcr_cap_word u_cap_word (
      .ccc(ccc),
      .diag_l1_exit_sel_a(diag_l1_exit_sel_a),
      .diag_l1_exit_sel_b(diag_l1_exit_sel_b),
      .cap_word(cap_word)
   );

   // ***********************************************************************
   // read and write answers
   // ***********************************************************************
   logic [31:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;
   logic wack_q, wack_d;

   always_comb begin
      rdata_d = rdata_q;
      rvalid_d = cfg_rd;
      wack_d = cfg_wr;
      if (cfg_rd) begin
         // reads are pure muxing, nothing is cleared or advanced
         if (hit_cap) begin
            rdata_d = cap_word;
         end else if (hit_ctrl) begin
            // upper half (link status) is outside this block and reads zero
            rdata_d = {16'h0000, lctl_word};
         end else begin
            rdata_d = `PLCR_RST_WORD;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= `PLCR_RST_WORD;
         rvalid_q <= `PLCR_RST_BIT;
         wack_q <= `PLCR_RST_BIT;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
         wack_q <= wack_d;
      end
   end

   assign cfg_rdata = rdata_q;
   assign cfg_rvalid = rvalid_q;
   assign cfg_wack = wack_q;
endmodule

// ==== hw/plcr_map.svh ====
// offsets, field positions and fixed values of the link capability block
`ifndef PLCR_MAP_SVH
`define PLCR_MAP_SVH

// ***********************************************************************
// configuration offsets (byte addresses)
// ***********************************************************************
`define PLCR_OFF_LINK_CAP 12'h07c
`define PLCR_OFF_LINK_CTRL 12'h080
`define PLCR_DWORD_LSB 2

// ***********************************************************************
// link capabilities fixed fields
// ***********************************************************************
`define PLCR_PORT_NUM 8'h00
`define PLCR_CAP_RSVD 2'h0
`define PLCR_BW_NOTIFY_CAP 1'h0
`define PLCR_DL_ACTIVE_CAP 1'h0
`define PLCR_SURPRISE_DOWN_CAP 1'h0
`define PLCR_REFCLK_GATING_CAP 1'h1
`define PLCR_L0S_EXIT_COMMON 3'h3
`define PLCR_L0S_EXIT_ASYNC 3'h4
`define PLCR_ASPM_SUPPORT 2'h3
`define PLCR_MAX_LANE_COUNT 6'h01
`define PLCR_MAX_SIGNAL_RATE 4'h1

// ***********************************************************************
// link control field positions
// ***********************************************************************
`define PLCR_LCTL_GATE_EN 8
`define PLCR_LCTL_EXT_SYNC 7
`define PLCR_LCTL_CCC 6
`define PLCR_LCTL_RCB 3
`define PLCR_LCTL_ASPM_HI 1
`define PLCR_LCTL_ASPM_LO 0
`define PLCR_BYTE_W 8

// ***********************************************************************
// reset values of plain control bits
// ***********************************************************************
`define PLCR_RST_BIT 1'h0
`define PLCR_RST_ASPM 2'h0
`define PLCR_RST_WORD 32'h0000_0000

`endif

// ==== hw/plcr_pkg.sv ====
// types shared by the link capability block
package plcr_pkg;
   typedef enum logic [0:0] {
      PLCR_ST_LOAD = 1'h0,
      PLCR_ST_RUN = 1'h1
   } plcr_state_t;
endpackage

// ==== hw/plcr_cap_word.sv ====
// assembly of the read-only link capabilities word
`timescale 1ns/100ps
`include "plcr_map.svh"
module plcr_cap_word
   import plcr_pkg::*;
(
   input wire logic ccc,
   input wire logic [2:0] diag_l1_exit_sel_a,
   input wire logic [2:0] diag_l1_exit_sel_b,
   output logic [31:0] cap_word
);
   logic [2:0] l1_exit_time;
   logic [2:0] l0s_exit_time;

   always_comb begin
      // common clock reads sel_a, separate clocks read sel_b
      l1_exit_time = ccc ? diag_l1_exit_sel_a : diag_l1_exit_sel_b;
      l0s_exit_time = ccc ? `PLCR_L0S_EXIT_COMMON : `PLCR_L0S_EXIT_ASYNC;
      cap_word = {`PLCR_PORT_NUM,
                  `PLCR_CAP_RSVD,
                  `PLCR_BW_NOTIFY_CAP,
                  `PLCR_DL_ACTIVE_CAP,
                  `PLCR_SURPRISE_DOWN_CAP,
                  `PLCR_REFCLK_GATING_CAP,
                  l1_exit_time,
                  l0s_exit_time,
                  `PLCR_ASPM_SUPPORT,
                  `PLCR_MAX_LANE_COUNT,
                  `PLCR_MAX_SIGNAL_RATE};
   end
endmodule

// ==== hw/plcr_link_ctrl.sv ====
// writable fields of the link control register
`timescale 1ns/100ps
`include "plcr_map.svh"
module plcr_link_ctrl
   import plcr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic load_defaults,
   input wire logic refclk_gating_default,
   input wire logic [1:0] aspm_control_default,
   input wire logic wr_lo,
   input wire logic wr_hi,
   input wire logic [15:0] wdata,
   output logic refclk_gating_enable,
   output logic extended_sync,
   output logic ccc,
   output logic rcb,
   output logic [1:0] aspm_control,
   output logic [15:0] lctl_word
);
   logic gate_q, gate_d;
   logic esync_q, esync_d;
   logic ccc_q, ccc_d;
   logic rcb_q, rcb_d;
   logic [1:0] aspm_q, aspm_d;

   always_comb begin
      gate_d = gate_q;
      esync_d = esync_q;
      ccc_d = ccc_q;
      rcb_d = rcb_q;
      aspm_d = aspm_q;
      if (load_defaults) begin
         // strap-like defaults taken after reset release, not under reset
         gate_d = refclk_gating_default;
         aspm_d = aspm_control_default;
      end else begin
         if (wr_hi) begin
            gate_d = wdata[`PLCR_LCTL_GATE_EN];
         end
         if (wr_lo) begin
            esync_d = wdata[`PLCR_LCTL_EXT_SYNC];
            ccc_d = wdata[`PLCR_LCTL_CCC];
            rcb_d = wdata[`PLCR_LCTL_RCB];
            aspm_d = wdata[`PLCR_LCTL_ASPM_HI:`PLCR_LCTL_ASPM_LO];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         gate_q <= `PLCR_RST_BIT;
         esync_q <= `PLCR_RST_BIT;
         ccc_q <= `PLCR_RST_BIT;
         rcb_q <= `PLCR_RST_BIT;
         aspm_q <= `PLCR_RST_ASPM;
      end else begin
         gate_q <= gate_d;
         esync_q <= esync_d;
         ccc_q <= ccc_d;
         rcb_q <= rcb_d;
         aspm_q <= aspm_d;
      end
   end

   always_comb begin
      // read-only bits of the register stay zero
      lctl_word = 16'h0000;
      lctl_word[`PLCR_LCTL_GATE_EN] = gate_q;
      lctl_word[`PLCR_LCTL_EXT_SYNC] = esync_q;
      lctl_word[`PLCR_LCTL_CCC] = ccc_q;
      lctl_word[`PLCR_LCTL_RCB] = rcb_q;
      lctl_word[`PLCR_LCTL_ASPM_HI:`PLCR_LCTL_ASPM_LO] = aspm_q;
   end

   assign refclk_gating_enable = gate_q;
   assign extended_sync = esync_q;
   assign ccc = ccc_q;
   assign rcb = rcb_q;
   assign aspm_control = aspm_q;
endmodule

// ==== verification/plcr_top_checker.sv ====
// assertions on the ports of the link capability block
`timescale 1ns/100ps
`include "plcr_map.svh"
module plcr_top_checker
   import plcr_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic cfg_rd,
   input wire logic cfg_wr,
   input wire logic [ADDR_W-1:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_rvalid,
   input wire logic cfg_wack,
   input wire logic [2:0] diag_l1_exit_sel_a,
   input wire logic [2:0] diag_l1_exit_sel_b,
   input wire logic refclk_gating_default,
   input wire logic [1:0] aspm_control_default,
   input wire logic refclk_gating_enable,
   input wire logic extended_sync,
   input wire logic ccc,
   input wire logic rcb,
   input wire logic [1:0] aspm_control
);
   // ******
   // helpers
   // ******
   localparam logic [ADDR_W-1:0] CAP_A = ADDR_W'(`PLCR_OFF_LINK_CAP);
   localparam logic [ADDR_W-1:0] CTL_A = ADDR_W'(`PLCR_OFF_LINK_CTRL);
   logic up_q;
   logic up_d;
   logic cap_hit;
   logic ctl_hit;
   assign cap_hit = cfg_addr[ADDR_W-1:2] == CAP_A[ADDR_W-1:2];
   assign ctl_hit = cfg_addr[ADDR_W-1:2] == CTL_A[ADDR_W-1:2];
   // low only in the load cycle, when writes are dropped
   always_comb up_d = 1'b1;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         up_q <= 1'b0;
      end else begin
         up_q <= up_d;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   sequence s_cap_rd;
      cfg_rd && cap_hit;
   endsequence
   sequence s_ctl_wr;
      cfg_wr && ctl_hit && up_q && cfg_be[0];
   endsequence
   sequence s_ctl_wr_hi;
      cfg_wr && ctl_hit && up_q && cfg_be[1];
   endsequence
   // ******
   // assertions
   // ******
   a_rd_answer: assert property (cfg_rd |=> cfg_rvalid)
      else $error("read not answered");
   a_cap_fixed: assert property (s_cap_rd |=>
      cfg_rdata[31:18] == 14'h0001 && cfg_rdata[11:0] == 12'hc11) else $error("cap fields");
   a_l1_common: assert property (s_cap_rd ##0 ccc |=>
      cfg_rdata[17:15] == $past(diag_l1_exit_sel_a)) else $error("l1 time common");
   a_l1_separate: assert property (s_cap_rd ##0 !ccc |=>
      cfg_rdata[17:15] == $past(diag_l1_exit_sel_b)) else $error("l1 time separate");
   a_l0s_exit: assert property (s_cap_rd |=>
      cfg_rdata[14:12] == ($past(ccc) ? 3'h3 : 3'h4)) else $error("l0s time");
   a_ctl_write: assert property (s_ctl_wr |=> ccc == $past(cfg_wdata[6]) &&
      rcb == $past(cfg_wdata[3]) && aspm_control == $past(cfg_wdata[1:0]) &&
      extended_sync == $past(cfg_wdata[7])) else $error("ctl write");
   a_gate_write: assert property (s_ctl_wr_hi |=>
      refclk_gating_enable == $past(cfg_wdata[8])) else $error("gate write");
   a_wr_answer: assert property (cfg_wr |=> cfg_wack)
      else $error("write not answered");
   a_cap_wr_inert: assert property (cfg_wr && cap_hit && up_q |=> $stable(ccc) &&
      $stable(aspm_control) && $stable(refclk_gating_enable)) else $error("cap write");
   a_load_defaults: assert property (!up_q |=> !ccc &&
      refclk_gating_enable == $past(refclk_gating_default) &&
      aspm_control == $past(aspm_control_default)) else $error("defaults");
   a_ctl_read: assert property (cfg_rd && ctl_hit |=>
      cfg_rdata[31:16] == 16'h0 && cfg_rdata[6] == $past(ccc)) else $error("ctl read");
endmodule
bind plcr_top plcr_top_checker #(.ADDR_W(ADDR_W)) i_plcr_top_checker (.ref_clk, .arst_n,
   .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rvalid, .cfg_wack,
   .diag_l1_exit_sel_a, .diag_l1_exit_sel_b, .refclk_gating_default, .aspm_control_default,
   .refclk_gating_enable, .extended_sync, .ccc, .rcb, .aspm_control);

// ==== verification/tb.sv ====
// self-checking bench for the link capability block
`timescale 1ns/100ps
`include "plcr_map.svh"
module tb
   import plcr_pkg::*;
;
   localparam logic [11:0] CAP = `PLCR_OFF_LINK_CAP;
   localparam logic [11:0] CTL = `PLCR_OFF_LINK_CTRL;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic cfg_rd = 1'b0;
   logic cfg_wr = 1'b0;
   logic [11:0] cfg_addr = 12'h000;
   logic [3:0] cfg_be = 4'h0;
   logic [31:0] cfg_wdata = 32'h0;
   logic [2:0] diag_l1_exit_sel_a = 3'h0;
   logic [2:0] diag_l1_exit_sel_b = 3'h0;
   logic refclk_gating_default = 1'b0;
   logic [1:0] aspm_control_default = 2'h0;
   logic [31:0] cfg_rdata;
   logic cfg_rvalid, cfg_wack, refclk_gating_enable, extended_sync, ccc, rcb;
   logic [1:0] aspm_control;
   logic [31:0] lfsr = 32'h54a6;
   // model of {gate, sync, common clock, rcb, aspm}
   logic [5:0] ctl_m = 6'h00;
   logic [31:0] rd_q[$];
   logic [5:0] wr_q[$];
   int mismatches = 0;
   int checks_done = 0;
   always #25 ref_clk = ~ref_clk;
   plcr_top i_plcr_top (.ref_clk, .arst_n, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata,
      .cfg_rdata, .cfg_rvalid, .cfg_wack, .diag_l1_exit_sel_a, .diag_l1_exit_sel_b,
      .refclk_gating_default, .aspm_control_default, .refclk_gating_enable, .extended_sync,
      .ccc, .rcb, .aspm_control);
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      if (mismatches == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // one request per falling edge; the next call or an idle call ends it
   task automatic op(input logic rd, input logic wr, input logic [11:0] a, input logic [3:0] be);
      logic [31:0] r;
      @(negedge ref_clk);
      r = rnd();
      {diag_l1_exit_sel_a, diag_l1_exit_sel_b} = r[21:16];
      cfg_rd = rd;
      cfg_wr = wr;
      cfg_addr = a | {10'h0, r[25:24]};
      cfg_be = be;
      cfg_wdata = r;
      // read sees the value before a write in the same cycle
      if (rd) rd_q.push_back(a == CAP ? {14'h0001, ctl_m[3] ? r[21:19] : r[18:16],
         ctl_m[3] ? 3'h3 : 3'h4, 12'hc11} : a == CTL ? {23'h0, ctl_m[5:3], 2'h0, ctl_m[2],
         1'b0, ctl_m[1:0]} : 32'h0);
      if (wr && a == CTL && be[0]) ctl_m[4:0] = {r[7], r[6], r[3], r[1:0]};
      if (wr && a == CTL && be[1]) ctl_m[5] = r[8];
      if (wr) wr_q.push_back(ctl_m);
   endtask
   task automatic do_reset(input int n);
      logic [31:0] r;
      @(negedge ref_clk);
      arst_n = 1'b0;
      cfg_rd = 1'b0;
      r = rnd();
      refclk_gating_default = r[0];
      aspm_control_default = r[2:1];
      ctl_m = {r[0], 3'h0, r[2:1]};
      repeat (n) @(negedge ref_clk);
      arst_n = 1'b1;
      // write in the load cycle must be dropped
      cfg_wr = 1'b1;
      cfg_addr = CTL;
      cfg_be = 4'h3;
      cfg_wdata = ~r;
      wr_q.push_back(ctl_m);
   endtask
   always @(posedge ref_clk) begin
      #1;
      if (cfg_rvalid === 1'b1) chk(cfg_rdata, rd_q.size() ? rd_q.pop_front() : 32'hx);
      if (cfg_wack === 1'b1) chk({refclk_gating_enable, extended_sync, ccc, rcb, aspm_control},
         wr_q.size() ? wr_q.pop_front() : 6'hx);
   end
   initial begin
      logic [31:0] r;
      do_reset(8);
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 60; i++) begin
            r = rnd();
            op(r[0], r[1], r[3] ? CTL : (r[2] ? CAP : 12'h100), r[7:4]);
         end
         repeat (3) op(1'b0, 1'b0, CTL, 4'h0);
         if (k == 0) do_reset(2);
      end
      for (int i = 0; i < 8 && rd_q.size() + wr_q.size() > 0; i++) @(posedge ref_clk);
      chk(rd_q.size() + wr_q.size(), 0);
      give_verdict();
   end
endmodule
